// ==== logic/sgnvm_regs.svh ====
`ifndef SGNVM_REGS_SVH
`define SGNVM_REGS_SVH
// ==========================================
// Check value
`define SGNVM_CRC_POLY   32'hedb88320
`define SGNVM_CRC_INIT   32'hffffffff
// ==========================================
// Station register offsets (byte addresses)
`define SGNVM_OFS_CMD    5'h00
`define SGNVM_OFS_DATA   5'h04
`define SGNVM_OFS_STATUS 5'h08
`define SGNVM_OFS_RAW    5'h0c
`define SGNVM_OFS_RD0    5'h10
`define SGNVM_OFS_RD1    5'h14
`define SGNVM_OFS_RD2    5'h18
// ==========================================
// Station command codes and fields
`define SGNVM_CMD_CALC   3'h1
`define SGNVM_CMD_UPDATE 3'h2
`define SGNVM_CMD_READSP 3'h3
`define SGNVM_CMD_GAIN   3'h4
`define SGNVM_CMD_AUTO   3'h5
`define SGNVM_SEL_LSB    4
// ==========================================
// Module status bits
`define SGNVM_ST_OOS     0
`define SGNVM_ST_NVMERR  1
`define SGNVM_ST_CRCERR  2
`define SGNVM_ST_REFUSED 3
`define SGNVM_ST_LOADED  4
`define SGNVM_ST_ADCRUN  5
`define SGNVM_ST_CALFAIL 6
// ==========================================
// Scale and limits
`define SGNVM_PCT_FULL   32'd10000
`define SGNVM_TOL_DEN    34'd100000
`define SGNVM_CAL_MAX    12'hfff
`endif

// ==== logic/sgnvm_pkg.sv ====
package sgnvm_pkg;
`include "sgnvm_regs.svh"

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_WRITE  = 3'h1,
    OP_READ   = 3'h2,
    OP_STATUS = 3'h3,
    OP_GAIN   = 3'h4,
    OP_AUTO   = 3'h5
  } sgnvm_op_t;

  // ==========================================
  // Reflected CRC-32 over one 32-bit word
  function automatic logic [31:0] sgnvm_crc32(input logic [31:0] d);
    logic [31:0] c;
    c = `SGNVM_CRC_INIT;
    for (int i = 0; i < 32; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ `SGNVM_CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction
endpackage

// ==== logic/sgnvm_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface sgnvm_link_if;
  import sgnvm_pkg::*;
  logic        ctb_en;
  logic        req_valid;
  sgnvm_op_t   req_op;
  logic [7:0]  req_addr;
  logic [31:0] req_data;
  logic [31:0] req_crc;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic [7:0]  rsp_status;

  modport station (output ctb_en, req_valid, req_op, req_addr, req_data, req_crc,
                   input rsp_valid, rsp_data, rsp_status);
  modport module_end (input ctb_en, req_valid, req_op, req_addr, req_data, req_crc,
                      output rsp_valid, rsp_data, rsp_status);
endinterface
`default_nettype wire

// ==== logic/sgnvm_station.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sgnvm_regs.svh"
module sgnvm_station import sgnvm_pkg::*; #(
  parameter int ADC_BITS = 16
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ctb_switch,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  sgnvm_link_if.station    link
);
  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_SEND  = 5'b00010,
    H_WAIT  = 5'b00100,
    H_STAT  = 5'b01000,
    H_SWAIT = 5'b10000
  } sgnvm_hst_t;

  sgnvm_hst_t  st;
  logic        ack;
  logic [2:0]  cmd;
  logic [3:0]  sel;
  logic [31:0] data_reg;
  logic [31:0] raw_reg;
  logic        calc_done;
  logic        refused;
  logic [1:0]  k;
  logic [7:0]  dev_stat;
  logic [31:0] rd [3];
  logic        wr_go;
  logic [63:0] next_raw;

  // ==========================================
  // Avalon slave: one wait state per access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack;
  assign next_raw = ({32'h0, data_reg} * 64'((1 << ADC_BITS) - 1)) / 64'(`SGNVM_PCT_FULL);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack) begin
      case (avs_address)
        `SGNVM_OFS_DATA:   avs_readdata <= data_reg;
        `SGNVM_OFS_STATUS: avs_readdata <= {16'h0, dev_stat, 4'h0, dev_stat[`SGNVM_ST_CRCERR],
                                            refused, calc_done, st != H_IDLE};
        `SGNVM_OFS_RAW:    avs_readdata <= raw_reg;
        `SGNVM_OFS_RD0:    avs_readdata <= rd[0];
        `SGNVM_OFS_RD1:    avs_readdata <= rd[1];
        `SGNVM_OFS_RD2:    avs_readdata <= rd[2];
        default:           avs_readdata <= 32'h0;
      endcase
    end
  end

  // ==========================================
  // Link drive
  assign link.ctb_en = ctb_switch;
  assign link.req_crc = sgnvm_crc32(link.req_data);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      link.req_valid <= 1'b0;
      link.req_op    <= OP_NONE;
      link.req_addr  <= 8'h0;
      link.req_data  <= 32'h0;
    end else begin
      link.req_valid <= (st == H_SEND) || (st == H_STAT);
      if (st == H_STAT) begin
        link.req_op <= OP_STATUS;
      end else if (st == H_SEND) begin
        case (cmd)
          `SGNVM_CMD_UPDATE: begin
            link.req_op   <= OP_WRITE;
            link.req_addr <= 8'({sel, 1'b0}) + 8'(sel) + 8'(k);
            link.req_data <= raw_reg;
          end
          `SGNVM_CMD_READSP: begin
            link.req_op   <= OP_READ;
            link.req_addr <= 8'({sel, 1'b0}) + 8'(sel) + 8'(k);
          end
          `SGNVM_CMD_GAIN: begin
            link.req_op   <= OP_GAIN;
            link.req_addr <= {4'h0, sel};
            link.req_data <= data_reg;
          end
          default: begin
            link.req_op   <= OP_AUTO;
            link.req_addr <= {4'h0, sel};
            link.req_data <= data_reg;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Command sequencer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st        <= H_IDLE;
      cmd       <= 3'h0;
      sel       <= 4'h0;
      data_reg  <= 32'h0;
      raw_reg   <= 32'h0;
      calc_done <= 1'b0;
      refused   <= 1'b0;
      k         <= 2'h0;
      dev_stat  <= 8'h0;
      rd[0]     <= 32'h0;
      rd[1]     <= 32'h0;
      rd[2]     <= 32'h0;
    end else begin
      case (st)
        H_IDLE: begin
          if (wr_go && avs_address == `SGNVM_OFS_DATA) begin
            data_reg <= avs_writedata;
          end
          if (wr_go && avs_address == `SGNVM_OFS_CMD) begin
            cmd     <= avs_writedata[2:0];
            sel     <= avs_writedata[`SGNVM_SEL_LSB +: 4];
            k       <= 2'h0;
            refused <= 1'b0;
            if (avs_writedata[2:0] == `SGNVM_CMD_CALC) begin
              raw_reg   <= next_raw[31:0];
              calc_done <= 1'b1;
            end else if (!ctb_switch || avs_writedata[2:0] > `SGNVM_CMD_AUTO ||
                         avs_writedata[2:0] == 3'h0) begin
              refused <= 1'b1;
            end else if (avs_writedata[2:0] == `SGNVM_CMD_UPDATE && !calc_done) begin
              refused <= 1'b1;
            end else begin
              st <= H_SEND;
            end
          end
        end
        H_SEND: st <= H_WAIT;
        H_WAIT: begin
          if (link.rsp_valid) begin
            if (cmd == `SGNVM_CMD_READSP) begin
              rd[k] <= link.rsp_data;
            end
            st <= H_STAT;
          end
        end
        H_STAT: st <= H_SWAIT;
        H_SWAIT: begin
          if (link.rsp_valid) begin
            dev_stat <= link.rsp_status;
            if ((cmd == `SGNVM_CMD_UPDATE || cmd == `SGNVM_CMD_READSP) && k != 2'h2) begin
              k  <= k + 2'h1;
              st <= H_SEND;
            end else begin
              if (cmd == `SGNVM_CMD_UPDATE) begin
                calc_done <= 1'b0;
              end
              st <= H_IDLE;
            end
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/sgnvm_safety_module.sv ====
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "sgnvm_regs.svh"
module sgnvm_safety_module import sgnvm_pkg::*; #(
  parameter int NUM_SP = 4,
  parameter int SP_W   = 16,
  parameter int GAIN_W = 16
) (
  input  wire logic                           mclk,
  input  wire logic                           rstn,
  sgnvm_link_if.module_end                    link,
  input  wire logic                           oos_switch,
  input  wire logic                           load_button,
  input  wire logic [NUM_SP-1:0][SP_W-1:0]    adc_data,
  input  wire logic [NUM_SP-1:0]              adc_valid,
  output logic      [NUM_SP-1:0][GAIN_W-1:0]  adc_gain,
  output logic                                adc_reset,
  output logic                                adc_run,
  output logic      [2:0][NUM_SP-1:0]         trip_bus,
  output logic                                nvm_led
);
  localparam int NLOC = 3 * NUM_SP;
  localparam int LW   = $clog2(NLOC);
  localparam int CW   = (NUM_SP > 1) ? $clog2(NUM_SP) : 1;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_WR   = 6'b000010,
    S_RB   = 6'b000100,
    S_GW   = 6'b001000,
    S_GA   = 6'b010000,
    S_CAL  = 6'b100000
  } sgnvm_dst_t;

  sgnvm_dst_t  st;
  // Stand-in for the nonvolatile parts: no reset, contents survive
  logic [31:0]       nvm_data [NLOC];
  logic [31:0]       nvm_crc  [NLOC];
  logic [GAIN_W-1:0] gain_nvm [NUM_SP];

  logic              fwd_valid;
  logic              hop_bad;
  sgnvm_op_t         fwd_op;
  logic [7:0]        fwd_addr;
  logic [31:0]       fwd_data;
  logic [31:0]       fwd_crc;
  logic [LW-1:0]     loc;
  logic [CW-1:0]     ch;
  logic [31:0]       wr_data;
  logic [GAIN_W-1:0] gain_val;
  logic [SP_W-1:0]   cal_ref;
  logic              cal_mode;
  logic              cal_pass;
  logic [11:0]       cal_cnt;
  logic              nvm_err;
  logic [LW-1:0]     err_loc;
  logic              crc_err;
  logic              refused;
  logic              cal_fail;
  logic              ld_busy;
  logic [CW-1:0]     ld_sp;
  logic              ld_btn_q;
  logic [CW:0]       pu_idx;
  logic [SP_W-1:0]   diff;
  logic [SP_W-1:0]   sample;
  logic [7:0]        status;

  assign status = {1'b0, cal_fail, adc_run, ~ld_busy, refused, crc_err, nvm_err, oos_switch};

  // ==========================================
  // Comm interface hop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fwd_valid <= 1'b0;
      hop_bad   <= 1'b0;
      fwd_op    <= OP_NONE;
      fwd_addr  <= 8'h0;
      fwd_data  <= 32'h0;
      fwd_crc   <= 32'h0;
    end else begin
      fwd_valid <= 1'b0;
      hop_bad   <= 1'b0;
      if (link.req_valid && link.ctb_en) begin
        if (link.req_crc == sgnvm_crc32(link.req_data)) begin
          fwd_valid <= 1'b1;
          fwd_op    <= link.req_op;
          fwd_addr  <= link.req_addr;
          fwd_data  <= link.req_data;
          fwd_crc   <= sgnvm_crc32(link.req_data);
        end else begin
          hop_bad <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // Nonvolatile stores
  always_ff @(posedge mclk) begin
    if (st == S_WR) begin
      nvm_data[loc] <= wr_data;
      nvm_crc[loc]  <= sgnvm_crc32(wr_data);
    end
    if (st == S_GW) begin
      gain_nvm[ch] <= gain_val;
    end
  end

  // ==========================================
  // Write, read-back, gain and calibration sequencer
  assign sample = adc_data[ch];
  assign diff = (sample > cal_ref) ? sample - cal_ref : cal_ref - sample;
  // Tolerance 1/100000 of the reference, no division needed
  assign cal_pass = ({18'h0, diff} * `SGNVM_TOL_DEN) <= {18'h0, cal_ref};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st              <= S_IDLE;
      loc             <= '0;
      ch              <= '0;
      wr_data         <= 32'h0;
      gain_val        <= '0;
      cal_ref         <= '0;
      cal_mode        <= 1'b0;
      cal_cnt         <= 12'h0;
      nvm_err         <= 1'b0;
      err_loc         <= '0;
      crc_err         <= 1'b0;
      refused         <= 1'b0;
      cal_fail        <= 1'b0;
      nvm_led         <= 1'b0;
      link.rsp_valid  <= 1'b0;
      link.rsp_data   <= 32'h0;
      link.rsp_status <= 8'h0;
    end else begin
      link.rsp_valid <= 1'b0;
      case (st)
        S_IDLE: begin
          if (hop_bad) begin
            crc_err         <= 1'b1;
            link.rsp_valid  <= 1'b1;
            link.rsp_status <= status | 8'h04;
          end else if (fwd_valid) begin
            loc      <= LW'(fwd_addr);
            ch       <= CW'(fwd_addr);
            wr_data  <= fwd_data;
            gain_val <= GAIN_W'(fwd_data);
            cal_ref  <= SP_W'(fwd_data);
            cal_cnt  <= 12'h0;
            crc_err  <= 1'b0;
            refused  <= 1'b0;
            // Status only moves with an answer, so it holds between answers
            if (fwd_crc != sgnvm_crc32(fwd_data)) begin
              crc_err         <= 1'b1;
              link.rsp_valid  <= 1'b1;
              link.rsp_status <= status | 8'h04;
            end else if (fwd_op == OP_STATUS) begin
              nvm_err         <= 1'b0;
              link.rsp_valid  <= 1'b1;
              link.rsp_status <= status;
            end else if (fwd_op == OP_READ && fwd_addr < 8'(NLOC)) begin
              link.rsp_data   <= nvm_data[LW'(fwd_addr)];
              link.rsp_valid  <= 1'b1;
              link.rsp_status <= status;
            end else if (!oos_switch || !adc_run || ld_busy) begin
              refused         <= 1'b1;
              link.rsp_valid  <= 1'b1;
              link.rsp_status <= status | 8'h08;
            end else if (fwd_op == OP_WRITE && fwd_addr < 8'(NLOC)) begin
              nvm_led <= 1'b1;
              st      <= S_WR;
            end else if ((fwd_op == OP_GAIN || fwd_op == OP_AUTO) && fwd_addr < 8'(NUM_SP)) begin
              cal_mode <= (fwd_op == OP_AUTO);
              cal_fail <= 1'b0;
              if (fwd_op == OP_AUTO) begin
                gain_val <= adc_gain[CW'(fwd_addr)];
                st       <= S_CAL;
              end else begin
                st <= S_GW;
              end
            end else begin
              refused         <= 1'b1;
              link.rsp_valid  <= 1'b1;
              link.rsp_status <= status | 8'h08;
            end
          end
        end
        S_WR: st <= S_RB;
        S_RB: begin
          link.rsp_valid <= 1'b1;
          link.rsp_data  <= nvm_data[loc];
          st             <= S_IDLE;
          if (sgnvm_crc32(nvm_data[loc]) != nvm_crc[loc]) begin
            nvm_err         <= 1'b1;
            err_loc         <= loc;
            link.rsp_status <= status | 8'h02;
          end else begin
            if (err_loc == loc) begin
              nvm_err <= 1'b0;
            end
            link.rsp_status <= status;
          end
        end
        S_GW: st <= S_GA;
        S_GA: begin
          if (cal_mode && !cal_pass) begin
            st <= S_CAL;
          end else begin
            link.rsp_valid  <= 1'b1;
            link.rsp_data   <= {{(32 - GAIN_W){1'b0}}, gain_val};
            link.rsp_status <= status;
            st              <= S_IDLE;
          end
        end
        S_CAL: begin
          if (adc_valid[ch]) begin
            cal_cnt <= cal_cnt + 12'h1;
            if (cal_pass) begin
              st <= S_GW;
            end else if (cal_cnt == `SGNVM_CAL_MAX) begin
              cal_fail        <= 1'b1;
              link.rsp_valid  <= 1'b1;
              link.rsp_status <= status | 8'h40;
              st              <= S_IDLE;
            end else begin
              gain_val <= (sample > cal_ref) ? gain_val - GAIN_W'(1) : gain_val + GAIN_W'(1);
              st       <= S_GW;
            end
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // ==========================================
  // Converter gains: power-up load, then live updates
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pu_idx    <= '0;
      adc_run   <= 1'b0;
      adc_reset <= 1'b1;
      adc_gain  <= '0;
    end else begin
      adc_reset <= 1'b0;
      if (!adc_run) begin
        adc_reset <= 1'b1;
        if (pu_idx == (CW + 1)'(NUM_SP)) begin
          adc_run <= 1'b1;
        end else begin
          adc_gain[CW'(pu_idx)] <= gain_nvm[CW'(pu_idx)];
          pu_idx <= pu_idx + (CW + 1)'(1);
        end
      end else if (st == S_GA) begin
        adc_gain[ch] <= gain_val;
        adc_reset    <= 1'b1;
      end
    end
  end

  // ==========================================
  // Setpoint loader; sole writer of running setpoints
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ld_busy  <= 1'b1;
      ld_sp    <= '0;
      ld_btn_q <= 1'b0;
    end else begin
      ld_btn_q <= load_button;
      if (ld_busy) begin
        if (ld_sp == CW'(NUM_SP - 1)) begin
          ld_busy <= 1'b0;
        end
        ld_sp <= (ld_sp == CW'(NUM_SP - 1)) ? '0 : ld_sp + CW'(1);
      end else if (load_button && !ld_btn_q) begin
        ld_busy <= 1'b1;
      end
    end
  end

  // ==========================================
  // Three trip copies, each only reading its own running setpoints
  for (genvar k = 0; k < 3; k++) begin : g_trip
    logic [NUM_SP-1:0][SP_W-1:0] run_sp;
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        run_sp      <= '0;
        trip_bus[k] <= '0;
      end else begin
        if (ld_busy) begin
          // Copy k always takes location 3*sp+k
          run_sp[ld_sp] <= SP_W'(nvm_data[LW'(3 * ld_sp + k)]);
        end
        for (int i = 0; i < NUM_SP; i++) begin
          trip_bus[k][i] <= adc_run && (adc_data[i] >= run_sp[i]);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/sgnvm_link_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module sgnvm_link_monitor import sgnvm_pkg::*; (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        ctb_en,
  input wire logic        req_valid,
  input var  sgnvm_op_t   req_op,
  input wire logic [7:0]  req_addr,
  input wire logic [31:0] req_data,
  input wire logic [31:0] req_crc,
  input wire logic        rsp_valid,
  input wire logic [31:0] rsp_data,
  input wire logic [7:0]  rsp_status
);
  sgnvm_op_t   last_op;
  logic [31:0] last_data;
  // Own copy of the check so a shared slip cannot hide
  function automatic logic [31:0] crc(input logic [31:0] d);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 32; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
    return ~c;
  endfunction
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      last_op   <= OP_NONE;
      last_data <= 32'h0;
    end else if (req_valid) begin
      last_op   <= req_op;
      last_data <= req_data;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ==========================================
  // Link checks
  crc_fwd_a: assert property (req_valid |-> req_crc == crc(req_data))
    else $error("request check value wrong");
  link_gate_a: assert property (req_valid |-> ctb_en)
    else $error("request without enable switch");
  one_out_a: assert property (req_valid |=> !req_valid [*2])
    else $error("second request outstanding");
  wr_time_a: assert property (req_valid && req_op == OP_WRITE |-> ##[2:4] rsp_valid)
    else $error("write not answered in time");
  rd_time_a: assert property (req_valid && req_op inside {OP_READ, OP_STATUS} |-> ##2 rsp_valid)
    else $error("read not answered in two cycles");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  rsp_hold_a: assert property (!rsp_valid |-> $stable(rsp_data) && $stable(rsp_status))
    else $error("response changed between answers");
  oos_refuse_a: assert property (rsp_valid && !rsp_status[0]
      && last_op inside {OP_WRITE, OP_GAIN, OP_AUTO} |-> rsp_status[3])
    else $error("change accepted while in service");
  wr_echo_a: assert property (rsp_valid && last_op == OP_WRITE && rsp_status[3:2] == 2'b00
      |-> rsp_data == last_data && !rsp_status[1])
    else $error("stored word differs or memory error");
  cover property (rsp_valid && last_op == OP_WRITE && !rsp_status[3]);
  cover property (rsp_valid && rsp_status[3]);
  cover property (rsp_valid && last_op == OP_READ);
  cover property (rsp_valid && last_op == OP_AUTO && !rsp_status[6]);
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top import sgnvm_pkg::*;;
  logic             mclk = 0, rstn = 0, ctb_switch = 1, oos_switch = 0, load_button = 0;
  logic [4:0]       avs_address = '0;
  logic             avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [31:0]      avs_writedata = '0, avs_readdata, q, r1, r2;
  logic [3:0][15:0] adc_data = '0, adc_gain, t;
  logic [3:0]       adc_valid = '0;
  logic [2:0][3:0]  trip_bus;
  logic             adc_reset, adc_run, nvm_led;
  logic [1:0]       s;
  int               seed = 95109, bad_count = 0, checked = 0, cyc = 0, p1, p2;
  sgnvm_link_if link();
  sgnvm_station i_sgnvm_station (.mclk(mclk), .rstn(rstn), .ctb_switch(ctb_switch),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  sgnvm_safety_module #(.NUM_SP(4)) i_sgnvm_safety_module (.mclk(mclk), .rstn(rstn),
    .link(link), .oos_switch(oos_switch), .load_button(load_button), .adc_data(adc_data),
    .adc_valid(adc_valid), .adc_gain(adc_gain), .adc_reset(adc_reset), .adc_run(adc_run),
    .trip_bus(trip_bus), .nvm_led(nvm_led));
  sgnvm_link_monitor u_mon (.mclk(mclk), .rstn(rstn), .ctb_en(link.ctb_en),
    .req_valid(link.req_valid), .req_op(link.req_op), .req_addr(link.req_addr),
    .req_data(link.req_data), .req_crc(link.req_crc), .rsp_valid(link.rsp_valid),
    .rsp_data(link.rsp_data), .rsp_status(link.rsp_status));
  always #2.5 mclk = ~mclk;
  // Random sample strobes pace the autocalibration steps
  always @(posedge mclk) begin
    adc_valid <= 4'($random(seed));
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("bad_count %0d checked %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // One Avalon access; the first edge keeps two requests from meeting in one step
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    // Only the cycle timeout ends a stuck access
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [3:0] sel, input logic [31:0] d);
    av(1, 5'h04, d);
    av(1, 5'h00, {24'h0, sel, 1'b0, c});
    do begin
      av(0, 5'h08, 0);
    end while (q[0] !== 1'b0);
  endtask
  task automatic rdback(input logic [31:0] e);
    cmd(3'h3, {2'b0, s}, 0);
    for (int k = 0; k < 3; k++) begin
      av(0, 5'(8'h10 + 4 * k), 0);
      chk("stored copy", e, q);
    end
  endtask
  task automatic load_trip(input logic e);
    load_button <= 1;
    repeat (3) @(posedge mclk);
    load_button <= 0;
    repeat (24) @(posedge mclk);
    for (int k = 0; k < 3; k++) chk("trip copy", 32'(e), 32'(trip_bus[k][s]));
  endtask
  function automatic logic [31:0] raw(input int p);
    return (32'(p) * 32'd65535) / 32'd10000;
  endfunction
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1;
    for (int i = 0; i < 50 && adc_run !== 1'b1; i++) @(posedge mclk);
    chk("adc_run", 1, 32'(adc_run));
    @(posedge mclk);
    chk("adc_reset", 0, 32'(adc_reset));
    av(0, 5'h1c, 0);
    chk("unmapped read", 0, q);
    s = 2'($random(seed));
    p1 = $unsigned($random(seed)) % 5000;
    p2 = 5000 + $unsigned($random(seed)) % 5001;
    r1 = raw(p1);
    r2 = raw(p2);
    t = {$random(seed), $random(seed)};
    t[s] = 16'((r1 + r2) / 2);
    adc_data <= t;
    oos_switch <= 1;
    cmd(3'h1, {2'b0, s}, p1);
    av(0, 5'h0c, 0);
    chk("raw setpoint", r1, q);
    cmd(3'h2, {2'b0, s}, p1);
    chk("nvm_led", 1, 32'(nvm_led));
    rdback(r1);
    load_trip(1);
    $display("test first update done");
    cmd(3'h2, {2'b0, s}, p1);
    chk("update without calc", 1, 32'(q[2]));
    cmd(3'h1, {2'b0, s}, p2);
    cmd(3'h2, {2'b0, s}, p2);
    rdback(r2);
    for (int k = 0; k < 3; k++) chk("running trip", 1, 32'(trip_bus[k][s]));
    load_trip(0);
    $display("test second update done");
    oos_switch <= 0;
    cmd(3'h1, {2'b0, s}, p1);
    cmd(3'h2, {2'b0, s}, p1);
    oos_switch <= 1;
    rdback(r2);
    $display("test in service done");
    r1 = 32'($random(seed) & 16'hffff);
    cmd(3'h4, {2'b0, s}, r1);
    chk("gain", r1, 32'(adc_gain[s]));
    cmd(3'h5, {2'b0, s}, 32'(t[s]));
    chk("autocal gain", r1, 32'(adc_gain[s]));
    chk("autocal fail flag", 0, 32'(q[14]));
    oos_switch <= 0;
    cmd(3'h4, {2'b0, s}, ~r1 & 32'h0000ffff);
    chk("gain in service", r1, 32'(adc_gain[s]));
    $display("test gain done");
    finish_test();
  end
endmodule
`default_nettype wire
